// *** rtl/itr_defines.svh ***
// Purpose: Constants of the two-wire target register port
// Assumes: Included by bare name from the register file, the target port and the bench
// Notes: Offsets are register offsets on the serial link
//
// Overview of operation
// [R01] Both sides drive lines open-drain only
// [R02] Idle bus: nobody pulls either line low
// [R03] Controller makes clock, address, start, stop
// [R04] Target only, 100k, 400k and 1M rates
// [R05] Standard and fast share one protocol
// [R06] Seven-bit address only, no general call
// [R07] Default own address is 0x5E
// [R08] Data falling while clock high is start
// [R09] Controller sends seven address bits, direction
// [R10] Data changes only while clock low
// [R11] Matching address: hold data low ninth clock
// [R12] Direction 0 writes, 1 reads
// [R13] Eight data bits then receiver acknowledge
// [R14] Stop releases bus, await new start
// [R15] Reads use repeated start, not stop-start
// [R16] Oscillator enabled once interface is accessible
// [R17] Load defaults from OTP before responding
// [R18] Rail enable and voltage select steer outputs
// [R19] Controller leaves reserved offsets untouched
// [R20] Write: address, offset, data, each acknowledged
// [R21] Read returns byte at written offset
`ifndef ITR_DEFINES_SVH
`define ITR_DEFINES_SVH
`define ITR_OWN_ADDR 7'h5e
`define ITR_BIT_LAST 3'h7
`define ITR_BIT_FIRST 3'h0
`define ITR_OFF_RAIL_EN 8'ha0
`define ITR_OFF_VSEL 8'h94
`define ITR_PTR_RST 8'h00
`define ITR_VSEL_W 7
`define ITR_CLK_NS 4
`define ITR_FMP_PERIOD_NS 1000
`define ITR_FMP_PERIOD_CYC (`ITR_FMP_PERIOD_NS / `ITR_CLK_NS)
`endif

// *** rtl/itr_pkg.sv ***
// Purpose: Types of the two-wire target register port
// Assumes: Nothing
// Notes: States are Gray coded along the usual path
package itr_pkg;
    typedef enum logic [2:0] {
        ITR_IDLE = 3'h0,
        ITR_ADDR = 3'h1,
        ITR_ADDR_ACK = 3'h3,
        ITR_WR_BYTE = 3'h2,
        ITR_WR_ACK = 3'h6,
        ITR_RD_BYTE = 3'h7,
        ITR_RD_ACK = 3'h5
    } itr_state_e;
endpackage

// *** rtl/itr_sync.sv ***
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes: Output moves only when second and third flops agree
`timescale 1ns/1ps
module itr_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_ff[i] <= 1'h1;
                    s2_ff[i] <= 1'h1;
                    s3_ff[i] <= 1'h1;
                    q_ff[i] <= 1'h1;
                end else begin
                    s1_ff[i] <= d[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i]) begin
                        q_ff[i] <= s3_ff[i];
                    end
                end
            end
        end
    endgenerate

    assign q = q_ff;
endmodule

// *** rtl/itr_regfile.sv ***
// Purpose: Register array loaded from OTP after reset
// Assumes: OTP data is valid in the cycle its address is shown
// Notes: Serial writes are blocked until the load walk ends
`timescale 1ns/1ps
`include "itr_defines.svh"
module itr_regfile #(
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    output logic [AW-1:0] otp_addr,
    input wire logic [7:0] otp_data,
    output logic ready,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [7:0] rail_en,
    output logic [`ITR_VSEL_W-1:0] vsel_code
);
    logic [7:0] mem [0:(1<<AW)-1];
    logic [AW-1:0] load_cnt_ff;
    logic ready_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            load_cnt_ff <= '0;
            ready_ff <= 1'h0;
        end else if (!ready_ff) begin
            load_cnt_ff <= load_cnt_ff + AW'(1);
            if (&load_cnt_ff) begin
                ready_ff <= 1'h1; // R17
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!ready_ff) begin
            mem[load_cnt_ff] <= otp_data; // R17
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data; // R18
        end
    end

    assign otp_addr = load_cnt_ff;
    assign ready = ready_ff;
    assign rd_data = mem[rd_addr];
    assign rail_en = mem[`ITR_OFF_RAIL_EN];
    assign vsel_code = mem[`ITR_OFF_VSEL][`ITR_VSEL_W-1:0];
endmodule

// *** rtl/itr_target_port.sv ***
// Purpose: Two-wire serial target giving access to device registers
// Assumes: SCL and SDA come from pins; CLK far faster than SCL
// Notes: Offset pointer auto-increments after each data byte
//        The falling SCL that closes a start is not counted as a data bit
`timescale 1ns/1ps
`include "itr_defines.svh"
module itr_target_port #(
    parameter logic [6:0] OWN_ADDR = `ITR_OWN_ADDR
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic [7:0] OTP_ADDR,
    input wire logic [7:0] OTP_DATA,
    output logic OSC_EN,
    output logic [7:0] RAIL_EN,
    output logic [`ITR_VSEL_W-1:0] VSEL_CODE,
    output logic ACTIVE
);
    itr_pkg::itr_state_e state_ff;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic rw_ff;
    logic first_ff;
    logic acked_ff;
    logic [7:0] ptr_ff;
    logic sda_oe_ff;
    logic ready;
    logic [7:0] rd_data;
    logic wr_en;
    logic [7:0] rx_byte;
    logic addr_ok;
    logic byte_end;
    logic armed_ff;

    function automatic logic addr_match(input logic [7:0] b, input logic [6:0] own);
        addr_match = (b[7:1] == own); // R06
    endfunction

    function automatic logic is_data_state(input itr_pkg::itr_state_e s);
        is_data_state = (s == itr_pkg::ITR_ADDR) || (s == itr_pkg::ITR_WR_BYTE) || (s == itr_pkg::ITR_RD_BYTE);
    endfunction

    itr_sync #(.W(2)) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .d({SCL_IN, SDA_IN}),
        .q(pins_s)
    );

    itr_regfile #(.AW(8)) u_regs (
        .clk(CLK),
        .rst(SYS_RST),
        .otp_addr(OTP_ADDR),
        .otp_data(OTP_DATA),
        .ready(ready),
        .wr_en(wr_en),
        .wr_addr(ptr_ff),
        .wr_data(rx_byte),
        .rd_addr(ptr_ff),
        .rd_data(rd_data),
        .rail_en(RAIL_EN),
        .vsel_code(VSEL_CODE)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Edge detection on filtered lines; one protocol for every rate
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
        end else begin
            scl_d_ff <= scl_s; // R05
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d_ff; // R04
    assign scl_fall = !scl_s && scl_d_ff; // R03
    assign start_ev = ready && scl_s && scl_d_ff && !sda_s && sda_d_ff; // R08
    assign stop_ev = scl_s && scl_d_ff && sda_s && !sda_d_ff; // R14
    assign byte_end = scl_fall && (bit_cnt_ff == `ITR_BIT_LAST);
    assign rx_byte = shift_ff;
    assign addr_ok = addr_match(shift_ff, OWN_ADDR); // R07
    assign wr_en = (state_ff == itr_pkg::ITR_WR_BYTE) && byte_end && !first_ff; // R20

    // Bit falls count only after a rise, so the fall closing a start is skipped
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            armed_ff <= 1'h0;
        end else if (start_ev || stop_ev) begin
            armed_ff <= 1'h0; // R08
        end else if (scl_rise) begin
            armed_ff <= 1'h1; // R09
        end
    end

    // Transfer sequencing
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_ff <= itr_pkg::ITR_IDLE;
        end else if (stop_ev) begin
            state_ff <= itr_pkg::ITR_IDLE; // R14
        end else if (start_ev) begin
            state_ff <= itr_pkg::ITR_ADDR; // R15
        end else if (scl_fall) begin
            unique case (state_ff)
                itr_pkg::ITR_IDLE: begin
                    state_ff <= itr_pkg::ITR_IDLE;
                end
                itr_pkg::ITR_ADDR: begin
                    if (bit_cnt_ff == `ITR_BIT_LAST) begin
                        state_ff <= addr_ok ? itr_pkg::ITR_ADDR_ACK : itr_pkg::ITR_IDLE; // R11
                    end
                end
                itr_pkg::ITR_ADDR_ACK: begin
                    state_ff <= rw_ff ? itr_pkg::ITR_RD_BYTE : itr_pkg::ITR_WR_BYTE; // R12
                end
                itr_pkg::ITR_WR_BYTE: begin
                    if (bit_cnt_ff == `ITR_BIT_LAST) begin
                        state_ff <= itr_pkg::ITR_WR_ACK; // R13
                    end
                end
                itr_pkg::ITR_WR_ACK: begin
                    state_ff <= itr_pkg::ITR_WR_BYTE;
                end
                itr_pkg::ITR_RD_BYTE: begin
                    if (bit_cnt_ff == `ITR_BIT_LAST) begin
                        state_ff <= itr_pkg::ITR_RD_ACK;
                    end
                end
                itr_pkg::ITR_RD_ACK: begin
                    state_ff <= acked_ff ? itr_pkg::ITR_RD_BYTE : itr_pkg::ITR_IDLE; // R21
                end
                default: begin
                    state_ff <= itr_pkg::ITR_IDLE;
                end
            endcase
        end
    end

    // Bit counter stepped on falling clock, receive shifter sampled on rising clock
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bit_cnt_ff <= `ITR_BIT_FIRST;
            shift_ff <= 8'h00;
        end else if (start_ev || stop_ev) begin
            bit_cnt_ff <= `ITR_BIT_FIRST;
        end else begin
            if (scl_rise) begin
                shift_ff <= {shift_ff[6:0], sda_s}; // R09
            end
            if (scl_fall && armed_ff && is_data_state(state_ff)) begin // R09
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
        end
    end

    // Direction, first-byte flag and controller acknowledge
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rw_ff <= 1'h0;
            first_ff <= 1'h0;
            acked_ff <= 1'h0;
        end else begin
            if (state_ff == itr_pkg::ITR_ADDR && byte_end) begin
                rw_ff <= shift_ff[0]; // R12
                first_ff <= 1'h1;
            end else if (state_ff == itr_pkg::ITR_WR_BYTE && byte_end) begin
                first_ff <= 1'h0; // R20
            end
            if (state_ff == itr_pkg::ITR_RD_ACK && scl_rise) begin
                acked_ff <= !sda_s; // R13
            end
        end
    end

    // Offset pointer survives a repeated start
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ptr_ff <= `ITR_PTR_RST;
        end else if (state_ff == itr_pkg::ITR_WR_BYTE && byte_end) begin
            ptr_ff <= first_ff ? shift_ff : ptr_ff + 8'h01; // R20
        end else if (state_ff == itr_pkg::ITR_RD_BYTE && byte_end) begin
            ptr_ff <= ptr_ff + 8'h01; // R21
        end
    end

    // Open-drain data drive, updated after a falling clock and cleared by start, stop or load
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sda_oe_ff <= 1'h0;
            tx_ff <= 8'h00;
        end else if (stop_ev || start_ev || !ready) begin
            sda_oe_ff <= 1'h0; // R02
        end else if (scl_fall) begin // R10
            unique case (state_ff)
                itr_pkg::ITR_ADDR: begin
                    sda_oe_ff <= (bit_cnt_ff == `ITR_BIT_LAST) && addr_ok; // R11
                end
                itr_pkg::ITR_WR_BYTE: begin
                    sda_oe_ff <= (bit_cnt_ff == `ITR_BIT_LAST); // R13
                end
                itr_pkg::ITR_ADDR_ACK, itr_pkg::ITR_RD_ACK: begin
                    if ((state_ff == itr_pkg::ITR_ADDR_ACK && rw_ff)
                            || (state_ff == itr_pkg::ITR_RD_ACK && acked_ff)) begin
                        tx_ff <= {rd_data[6:0], 1'h0}; // R21
                        sda_oe_ff <= !rd_data[7];
                    end else begin
                        sda_oe_ff <= 1'h0;
                    end
                end
                itr_pkg::ITR_RD_BYTE: begin
                    tx_ff <= {tx_ff[6:0], 1'h0};
                    sda_oe_ff <= (bit_cnt_ff != `ITR_BIT_LAST) && !tx_ff[7];
                end
                default: begin
                    sda_oe_ff <= 1'h0;
                end
            endcase
        end
    end

    assign SDA_OUT = 1'h0; // R01
    assign SDA_OE = sda_oe_ff;
    assign OSC_EN = ready; // R16
    assign ACTIVE = |RAIL_EN; // R18

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    open_drain_a: assert property (SDA_OUT == 1'h0) // R01
        else $error("data pin driven high");
    idle_release_a: assert property (state_ff == itr_pkg::ITR_IDLE && !scl_fall |=> !SDA_OE) // R02
        else $error("bus held while idle");
    start_seen_a: assert property (start_ev |=> state_ff == itr_pkg::ITR_ADDR && bit_cnt_ff == `ITR_BIT_FIRST) // R08
        else $error("start not taken");
    addr_ack_a: assert property (state_ff == itr_pkg::ITR_ADDR && byte_end && addr_ok && !start_ev && !stop_ev // R11
        |=> SDA_OE && state_ff == itr_pkg::ITR_ADDR_ACK)
        else $error("own address not acknowledged");
    foreign_addr_a: assert property (state_ff == itr_pkg::ITR_ADDR && byte_end && !addr_ok // R06
        |=> !SDA_OE && state_ff == itr_pkg::ITR_IDLE)
        else $error("foreign address answered");
    stop_release_a: assert property (stop_ev |=> state_ff == itr_pkg::ITR_IDLE && !SDA_OE) // R14
        else $error("stop did not release bus");
    sda_low_phase_a: assert property ($changed(sda_oe_ff) && ready && $past(ready) && !$past(start_ev) // R10
        && !$past(stop_ev) |-> !scl_s)
        else $error("data moved while clock high");
    load_silent_a: assert property (!ready |-> !SDA_OE ##1 !SDA_OE) // R17
        else $error("answered before defaults loaded");
    reg_write_a: assert property (wr_en && ptr_ff == `ITR_OFF_RAIL_EN |=> RAIL_EN == $past(rx_byte)) // R18
        else $error("rail enable write lost");
    read_data_a: assert property (state_ff == itr_pkg::ITR_ADDR_ACK && scl_fall && rw_ff && !start_ev && !stop_ev // R21
        |=> SDA_OE == !$past(rd_data[7]))
        else $error("read byte not from pointer");

    // Byte framing, acknowledge timing, pointer steps and load blocking
    bit_skip_a: assert property (scl_fall && !armed_ff |=> bit_cnt_ff == `ITR_BIT_FIRST) // R09
        else $error("start fall counted as a data bit");
    count_hold_a: assert property (!is_data_state(state_ff) && !start_ev && !stop_ev // R13
        |=> bit_cnt_ff == $past(bit_cnt_ff))
        else $error("bit count moved outside a byte");
    write_ack_a: assert property (state_ff == itr_pkg::ITR_WR_BYTE && byte_end // R13
        |=> SDA_OE && state_ff == itr_pkg::ITR_WR_ACK)
        else $error("written byte not acknowledged");
    ack_release_a: assert property (state_ff == itr_pkg::ITR_WR_ACK && scl_fall // R13
        |=> !SDA_OE && state_ff == itr_pkg::ITR_WR_BYTE)
        else $error("acknowledge held past ninth clock");
    ack_hold_a: assert property (state_ff == itr_pkg::ITR_ADDR_ACK && !scl_fall && !start_ev && !stop_ev // R11
        |=> SDA_OE)
        else $error("address acknowledge dropped early");
    read_release_a: assert property (state_ff == itr_pkg::ITR_RD_BYTE && byte_end // R13
        |=> !SDA_OE && state_ff == itr_pkg::ITR_RD_ACK)
        else $error("data line held during controller acknowledge");
    nack_release_a: assert property (state_ff == itr_pkg::ITR_RD_ACK && scl_fall && !acked_ff // R21
        |=> !SDA_OE && state_ff == itr_pkg::ITR_IDLE)
        else $error("read went on after controller nack");
    ptr_step_a: assert property (state_ff == itr_pkg::ITR_RD_BYTE && byte_end // R21
        |=> ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("read pointer did not advance");
    offset_load_a: assert property (state_ff == itr_pkg::ITR_WR_BYTE && byte_end && first_ff // R20
        |=> ptr_ff == $past(shift_ff))
        else $error("offset byte not taken as pointer");
    start_block_a: assert property (!ready |=> state_ff == itr_pkg::ITR_IDLE) // R17
        else $error("transfer started before defaults loaded");

    // Main transfer scenarios
    write_xfer_c: cover property (wr_en ##[1:1000] stop_ev);
    read_ack_c: cover property (state_ff == itr_pkg::ITR_RD_ACK && scl_rise && !sda_s);
    read_nack_c: cover property (state_ff == itr_pkg::ITR_RD_ACK && scl_rise && sda_s);
    repeated_start_c: cover property (state_ff == itr_pkg::ITR_WR_BYTE && start_ev);
    foreign_addr_c: cover property (state_ff == itr_pkg::ITR_ADDR && byte_end && !addr_ok);
endmodule

// *** verification/itr_ctl_model.sv ***
// Purpose: Two-wire bus controller model that drives the target port
// Assumes: SDA is open-drain with a pull-up and a released SDA reads high; SCL is driven both high and low
// Notes: half is the SCL half period in ns and sets the bus rate
`timescale 1ns/1ps
module itr_ctl_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    real half = 24.0;

    // Idle: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start, or repeated start when SCL is low
    task automatic start();
        #(half / 2);
        sda_low = 1'b0;
        #(half / 2);
        scl = 1'b1;
        #(half / 2);
        sda_low = 1'b1;
        #(half / 2);
        scl = 1'b0;
    endtask

    task automatic stop();
        #(half / 2);
        sda_low = 1'b1;
        #(half / 2);
        scl = 1'b1;
        #(half / 2);
        sda_low = 1'b0;
        #half;
    endtask

    // One clock pulse; data changes only while SCL is low
    task automatic clk_bit(input logic b, output logic s);
        #(half / 2);
        sda_low = ~b;
        #(half / 2);
        scl = 1'b1;
        #(half / 2);
        s = sda;
        #(half / 2);
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then the target's acknowledge (0 = acked)
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, ack);
    endtask

    // Eight bits from the target, then our acknowledge or, when last, none
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(last, s);
    endtask
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the two-wire target register port
// Assumes: OTP holds offset xor 3c, except 00 at the rail enable offset
// Notes: Runs at 48 ns bus period, with one write at 1 Mbps and one read at 400 kbps
`timescale 1ns/1ps
`include "itr_defines.svh"
module tb;
    logic clk;
    logic sys_rst;
    logic [7:0] otp_addr;
    logic [7:0] otp_data;
    logic sda_out;
    logic sda_oe;
    logic osc_en;
    logic [7:0] rail_en;
    logic [`ITR_VSEL_W-1:0] vsel_code;
    logic active;
    wire scl;
    wire sda_low;
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    int miscompares = 0;
    int checks_done = 0;

    assign otp_data = (otp_addr == `ITR_OFF_RAIL_EN) ? 8'h00 : (otp_addr ^ 8'h3c);

    itr_target_port itr_target_port_inst (.CLK(clk), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .OTP_ADDR(otp_addr), .OTP_DATA(otp_data), .OSC_EN(osc_en),
        .RAIL_EN(rail_en), .VSEL_CODE(vsel_code), .ACTIVE(active));
    itr_ctl_model itr_ctl_model_inst (.scl(scl), .sda_low(sda_low), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic idle_chk();
        repeat (8) @(posedge clk);
        chk("released after stop", 8'h00, {7'h0, sda_oe});
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1, input logic two);
        logic a;
        itr_ctl_model_inst.start();
        itr_ctl_model_inst.put_byte({`ITR_OWN_ADDR, 1'b0}, a);
        chk("address ack", 8'h00, {7'h0, a});
        itr_ctl_model_inst.put_byte(off, a);
        chk("offset ack", 8'h00, {7'h0, a});
        itr_ctl_model_inst.put_byte(d0, a);
        chk("data ack", 8'h00, {7'h0, a});
        if (two) begin
            itr_ctl_model_inst.put_byte(d1, a);
            chk("second data ack", 8'h00, {7'h0, a});
        end
        itr_ctl_model_inst.stop();
        idle_chk();
    endtask

    task automatic rd(input logic [7:0] off, output logic [7:0] d0, output logic [7:0] d1);
        logic a;
        itr_ctl_model_inst.start();
        itr_ctl_model_inst.put_byte({`ITR_OWN_ADDR, 1'b0}, a);
        itr_ctl_model_inst.put_byte(off, a);
        chk("read offset ack", 8'h00, {7'h0, a});
        itr_ctl_model_inst.start();
        itr_ctl_model_inst.put_byte({`ITR_OWN_ADDR, 1'b1}, a);
        chk("read address ack", 8'h00, {7'h0, a});
        itr_ctl_model_inst.get_byte(1'b0, d0);
        itr_ctl_model_inst.get_byte(1'b1, d1);
        itr_ctl_model_inst.stop();
        idle_chk();
    endtask

    task automatic t_load();
        int n;
        n = 0;
        while (osc_en !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("oscillator on", 8'h01, {7'h0, osc_en});
        chk("rail enable default", 8'h00, rail_en);
        chk("voltage code default", 8'h28, {1'b0, vsel_code});
        chk("active default", 8'h00, {7'h0, active});
        $display("test load done");
    endtask

    task automatic t_fast_plus_write();
        itr_ctl_model_inst.half = 500.0;
        wr(`ITR_OFF_RAIL_EN, 8'h01, 8'h00, 1'b0);
        chk("rail enable written", 8'h01, rail_en);
        chk("active after enable", 8'h01, {7'h0, active});
        itr_ctl_model_inst.half = 24.0;
        $display("test fast plus write done");
    endtask

    task automatic t_write_read_back();
        logic [7:0] d0;
        logic [7:0] d1;
        wr(`ITR_OFF_VSEL, 8'h15, 8'h33, 1'b1);
        chk("voltage code written", 8'h15, {1'b0, vsel_code});
        rd(`ITR_OFF_VSEL, d0, d1);
        chk("read first byte", 8'h15, d0);
        chk("read second byte", 8'h33, d1);
        $display("test write read back done");
    endtask

    task automatic t_refuse();
        logic [7:0] adr [3] = '{8'h00, 8'hf0, 8'hbe};
        logic a;
        for (int i = 0; i < 3; i++) begin
            itr_ctl_model_inst.start();
            itr_ctl_model_inst.put_byte(adr[i], a);
            chk("foreign address nack", 8'h01, {7'h0, a});
            itr_ctl_model_inst.put_byte(8'ha0, a);
            chk("ignored byte nack", 8'h01, {7'h0, a});
            itr_ctl_model_inst.stop();
        end
        chk("rail enable kept", 8'h01, rail_en);
        $display("test refuse done");
    endtask

    task automatic t_fast_read();
        logic [7:0] d0;
        logic [7:0] d1;
        itr_ctl_model_inst.half = 1250.0;
        rd(8'h10, d0, d1);
        chk("fast read first", 8'h2c, d0);
        chk("fast read second", 8'h2d, d1);
        $display("test fast read done");
    endtask

    initial begin
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("reset data release", 8'h00, {7'h0, sda_oe});
        chk("reset oscillator off", 8'h00, {7'h0, osc_en});
        @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_load();
        t_fast_plus_write();
        t_write_read_back();
        t_refuse();
        t_fast_read();
        report_and_stop();
    end

    initial begin
        #300000;
        miscompares++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
